// ==== src/sts_tx_port.sv ====
// Transmit client port: segmented stream intake, error word substitution, underflow and registers
////////////////////////////////////////////////////////////////////////////////
// Contract
// - A transfer completes only when valid is one; otherwise bus contents ignored.
// - Transmit data bus is 128 bits wide carrying packet data.
// - Bus splits into segments 0 and 1, each 64 bits or 8 bytes.
// - Packets may start and end in either segment, back to back.
// - Segment data moves only when its enable and valid are both high.
// - Three-bit empty count gives trailing unused bytes; zero means all valid.
// - Empty count is sampled only when valid and end are both one.
// - Bad flag sampled only with enable and end; client holds it zero otherwise.
// - Bad flag at end replaces that last data word with the error control code.
// - A bad packet disables FCS checking and reporting for that packet only.
// - Underflow indicator rises when an in-progress frame is not fed data.
// - All interface signals are synchronous to the rising edge of the clock; reset_n here clears the port asynchronously.
module sts_tx_port (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_address,
	input wire logic [31:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_read_data,
	output logic irq,
	output logic tready,
	input wire logic tvalid,
	input wire logic [127:0] tdata,
	input wire logic segment0_enable,
	input wire logic segment1_enable,
	input wire logic segment0_packet_start,
	input wire logic segment1_packet_start,
	input wire logic segment0_packet_end,
	input wire logic segment1_packet_end,
	input wire logic segment0_packet_bad,
	input wire logic segment1_packet_bad,
	input wire logic [2:0] segment0_empty_count,
	input wire logic [2:0] segment1_empty_count,
	input wire logic link_ready,
	output logic [127:0] link_data,
	output logic [1:0] link_valid,
	output logic [1:0] link_start,
	output logic [1:0] link_end,
	output logic [1:0] link_no_fcs,
	output logic [2:0] link_empty0,
	output logic [2:0] link_empty1,
	output logic underflow
);
	////////////////////////////////////////////////////////////////////////////////
	sts_pkg::sts_state_s state;
	sts_pkg::sts_state_s next_state;
	logic [1:0] seg_enable;
	logic [1:0] seg_start;
	logic [1:0] seg_end;
	logic [1:0] seg_bad;
	logic [5:0] seg_empty;
	logic take;

	function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
		reg_hit = strobe && (addr == target);
	endfunction : reg_hit

	assign seg_enable = {segment1_enable, segment0_enable};
	assign seg_start = {segment1_packet_start, segment0_packet_start};
	assign seg_end = {segment1_packet_end, segment0_packet_end};
	assign seg_bad = {segment1_packet_bad, segment0_packet_bad};
	assign seg_empty = {segment1_empty_count, segment0_empty_count};

	// Ready is combinational so a downstream stall stops intake in the same cycle
	assign tready = state.enable && link_ready;
	assign take = tvalid && tready;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic in_pkt;
		logic [2:0] set_bits;
		logic [2:0] clear_bits;
		logic [15:0] done_count;
		in_pkt = state.in_packet;
		set_bits = 3'h0;
		clear_bits = 3'h0;
		done_count = state.packets;
		next_state = state;
		next_state.valid = 2'h0;
		next_state.start = 2'h0;
		next_state.finish = 2'h0;
		next_state.no_fcs = 2'h0;
		next_state.empty = 6'h0;
		next_state.underflow = 1'b0;
		next_state.rdata = 32'h0000_0000;
		// A running frame with a ready cycle and no enabled segment starves the line
		if (state.in_packet && tready && !(tvalid && (seg_enable != 2'h0)))
		begin
			next_state.underflow = 1'b1;
			set_bits[sts_pkg::EVENT_UNDERFLOW_BIT] = 1'b1;
		end
		// Segment 0 first, so a packet ending in 0 may restart in 1
		for (int s = 0; s < sts_pkg::SEG_N; s++)
		begin
			if (take && seg_enable[s])
			begin
				next_state.valid[s] = 1'b1;
				next_state.data[s*sts_pkg::SEG_W +: sts_pkg::SEG_W] = tdata[s*sts_pkg::SEG_W +: sts_pkg::SEG_W];
				if (seg_start[s])
				begin
					in_pkt = 1'b1;
					next_state.start[s] = 1'b1;
				end
				if (seg_end[s])
				begin
					in_pkt = 1'b0;
					next_state.finish[s] = 1'b1;
					next_state.empty[s*sts_pkg::EMPTY_W +: sts_pkg::EMPTY_W] =
						seg_empty[s*sts_pkg::EMPTY_W +: sts_pkg::EMPTY_W];
					set_bits[sts_pkg::EVENT_DONE_BIT] = 1'b1;
					done_count = done_count + 16'h0001;
					if (seg_bad[s])
					begin
						next_state.data[s*sts_pkg::SEG_W +: sts_pkg::SEG_W] = sts_pkg::ERROR_WORD;
						next_state.no_fcs[s] = 1'b1;
						set_bits[sts_pkg::EVENT_BAD_BIT] = 1'b1;
					end
				end
			end
		end
		next_state.in_packet = in_pkt;
		next_state.packets = done_count;
		if (reg_hit(reg_write, reg_address, sts_pkg::CONTROL_ADDR))
			next_state.enable = reg_write_data[sts_pkg::CONTROL_ENABLE_BIT];
		if (reg_hit(reg_write, reg_address, sts_pkg::MASK_ADDR))
			next_state.mask = reg_write_data[2:0];
		if (reg_hit(reg_write, reg_address, sts_pkg::EVENT_ADDR))
			clear_bits = reg_write_data[2:0];
		// A new event in the clearing cycle survives the clear
		next_state.event_bits = (state.event_bits & ~clear_bits) | set_bits;
		if (reg_read)
		begin
			case (reg_address)
				sts_pkg::CONTROL_ADDR:
					next_state.rdata[sts_pkg::CONTROL_ENABLE_BIT] = state.enable;
				sts_pkg::STATE_ADDR:
				begin
					next_state.rdata[sts_pkg::STATE_IN_PACKET_BIT] = state.in_packet;
					next_state.rdata[sts_pkg::STATE_READY_BIT] = tready;
				end
				sts_pkg::EVENT_ADDR:
					next_state.rdata[2:0] = state.event_bits;
				sts_pkg::MASK_ADDR:
					next_state.rdata[2:0] = state.mask;
				sts_pkg::PACKETS_ADDR:
					next_state.rdata[15:0] = state.packets;
				default:
					next_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= '0;
			state.enable <= sts_pkg::CONTROL_ENABLE_RESET;
			state.mask <= sts_pkg::MASK_RESET;
		end
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign reg_read_data = state.rdata;
	assign irq = |(state.event_bits & state.mask);
	assign link_data = state.data;
	assign link_valid = state.valid;
	assign link_start = state.start;
	assign link_end = state.finish;
	assign link_no_fcs = state.no_fcs;
	assign link_empty0 = state.empty[2:0];
	assign link_empty1 = state.empty[5:3];
	assign underflow = state.underflow;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence seg0_taken_s;
		tvalid && tready && segment0_enable;
	endsequence

	sequence seg0_bad_end_s;
		seg0_taken_s ##0 (segment0_packet_end && segment0_packet_bad);
	endsequence

	sequence frame_open_s;
		tvalid && tready && segment0_enable && segment0_packet_start && !segment0_packet_end
			&& !segment1_enable;
	endsequence

	sequence seg1_taken_s;
		tvalid && tready && segment1_enable;
	endsequence

	sequence seg1_bad_end_s;
		seg1_taken_s ##0 (segment1_packet_end && segment1_packet_bad);
	endsequence

	ready_gate_a: assert property (!tready |=> link_valid == 2'h0)
		else $error("Data accepted while ready low");
	valid_gate_a: assert property (!tvalid |=> link_valid == 2'h0)
		else $error("Data accepted without valid");
	seg_enable_a: assert property (tvalid && tready |=> link_valid == $past(seg_enable))
		else $error("Segment valid does not follow its enable");
	seg_data_a: assert property (seg0_taken_s ##0 !segment0_packet_bad
		|=> link_data[63:0] == $past(tdata[63:0]))
		else $error("Segment 0 data not passed in low half");
	empty_sample_a: assert property (tvalid && tready && segment1_enable && !segment1_packet_end
		|=> link_empty1 == 3'h0)
		else $error("Empty count passed outside end cycle");
	error_word_a: assert property (seg0_bad_end_s
		|=> link_data[63:0] == sts_pkg::ERROR_WORD && link_no_fcs[0])
		else $error("Bad end not replaced by error word");
	fcs_once_a: assert property (seg0_bad_end_s ##1 (tvalid && tready && segment0_enable
		&& !segment0_packet_bad) |=> !link_no_fcs[0])
		else $error("FCS suppression leaked into next packet");
	underflow_flag_a: assert property (frame_open_s ##1 (tready && !tvalid)
		|=> underflow ##1 state.event_bits[sts_pkg::EVENT_UNDERFLOW_BIT])
		else $error("Starved frame did not flag underflow");
	straddle_a: assert property (tvalid && tready && (seg_enable == 2'h3) && segment0_packet_end
		&& segment1_packet_start && !segment1_packet_end |=> state.in_packet)
		else $error("Packet starting in segment 1 not tracked");
	irq_mask_a: assert property (underflow && state.mask[sts_pkg::EVENT_UNDERFLOW_BIT] |-> irq)
		else $error("Masked-in underflow did not raise interrupt");

	// Per-segment sideband passes only for taken, enabled segments
	start_follow_a: assert property (tvalid && tready |=> link_start == $past(seg_start & seg_enable))
		else $error("Start flags do not follow enabled segments");
	end_follow_a: assert property (tvalid && tready |=> link_end == $past(seg_end & seg_enable))
		else $error("End flags do not follow enabled segments");
	bad_gate_a: assert property (tvalid && tready
		|=> link_no_fcs == $past(seg_bad & seg_end & seg_enable))
		else $error("FCS suppression outside a bad end segment");
	seg1_data_a: assert property (seg1_taken_s ##0 !segment1_packet_bad
		|=> link_data[127:64] == $past(tdata[127:64]))
		else $error("Segment 1 data not passed in high half");
	error_word1_a: assert property (seg1_bad_end_s
		|=> link_data[127:64] == sts_pkg::ERROR_WORD && link_no_fcs[1])
		else $error("Bad end in segment 1 not replaced by error word");
	empty_pass_a: assert property (seg0_taken_s ##0 segment0_packet_end
		|=> link_empty0 == $past(segment0_empty_count))
		else $error("Empty count of an end segment not passed");
	empty_zero_a: assert property (!(tvalid && tready && segment0_enable && segment0_packet_end)
		|=> link_empty0 == 3'h0)
		else $error("Empty count passed without an end segment");
	data_hold_a: assert property (!(tvalid && tready) |=> $stable(link_data))
		else $error("Link data changed without a transfer");
	ready_link_a: assert property (!link_ready |-> !tready)
		else $error("Ready raised while the link stalls");
	straddle_end_a: assert property (tvalid && tready && (seg_enable == 2'h3) && segment0_packet_start
		&& !segment0_packet_end && segment1_packet_end && !segment1_packet_start |=> !state.in_packet)
		else $error("Packet ending in segment 1 left open");

	// Underflow, events and packet counter
	underflow_gate_a: assert property (!state.in_packet |=> !underflow)
		else $error("Underflow outside a running frame");
	underflow_event_a: assert property (underflow |-> state.event_bits[sts_pkg::EVENT_UNDERFLOW_BIT])
		else $error("Underflow pulse without its event bit");
	done_event_a: assert property (seg1_taken_s ##0 segment1_packet_end
		|=> state.event_bits[sts_pkg::EVENT_DONE_BIT])
		else $error("Packet end did not set its event bit");
	bad_event_a: assert property (seg1_bad_end_s |=> state.event_bits[sts_pkg::EVENT_BAD_BIT])
		else $error("Bad packet did not set its event bit");
	packet_count_a: assert property (tvalid && tready
		|=> state.packets == $past(state.packets) + 16'($countones($past(seg_end & seg_enable))))
		else $error("Packet counter does not follow taken end segments");
	event_clear_a: assert property (reg_write && reg_address == sts_pkg::EVENT_ADDR
		&& reg_write_data[sts_pkg::EVENT_DONE_BIT] && !(tvalid && tready && |(seg_end & seg_enable))
		|=> !state.event_bits[sts_pkg::EVENT_DONE_BIT])
		else $error("Event bit not cleared by writing a one");

	// Register port: read data stands one cycle, writes land at the strobe edge
	read_idle_a: assert property (!reg_read |=> reg_read_data == 32'h0000_0000)
		else $error("Read data shown without a read strobe");
	read_mask_a: assert property (reg_read && reg_address == sts_pkg::MASK_ADDR
		|=> reg_read_data == {29'h0, $past(state.mask)})
		else $error("Mask register read back wrong");
	read_event_a: assert property (reg_read && reg_address == sts_pkg::EVENT_ADDR
		|=> reg_read_data == {29'h0, $past(state.event_bits)})
		else $error("Event register read back wrong");
	read_state_a: assert property (reg_read && reg_address == sts_pkg::STATE_ADDR
		|=> reg_read_data[sts_pkg::STATE_READY_BIT] == $past(tready))
		else $error("State register does not show ready");
	read_packets_a: assert property (reg_read && reg_address == sts_pkg::PACKETS_ADDR
		|=> reg_read_data == {16'h0000, $past(state.packets)})
		else $error("Packet counter read back wrong");
	mask_write_a: assert property (reg_write && reg_address == sts_pkg::MASK_ADDR
		|=> state.mask == $past(reg_write_data[2:0]))
		else $error("Mask write did not land");
	enable_write_a: assert property (reg_write && reg_address == sts_pkg::CONTROL_ADDR
		|=> state.enable == $past(reg_write_data[sts_pkg::CONTROL_ENABLE_BIT]))
		else $error("Enable write did not land");
endmodule : sts_tx_port

// ==== pkg/sts_pkg.sv ====
// Constants and state type of the segmented transmit stream port
package sts_pkg;
	localparam int DATA_W = 128;
	localparam int SEG_W = 64;
	localparam int SEG_N = 2;
	localparam int EMPTY_W = 3;
	localparam int ADDR_W = 8;
	localparam int REG_W = 32;
	localparam int COUNT_W = 16;
	localparam int EVENT_N = 3;

	// Register byte offsets
	localparam logic [7:0] CONTROL_ADDR = 8'h00;
	localparam logic [7:0] STATE_ADDR = 8'h04;
	localparam logic [7:0] EVENT_ADDR = 8'h08;
	localparam logic [7:0] MASK_ADDR = 8'h0C;
	localparam logic [7:0] PACKETS_ADDR = 8'h10;

	// Field positions
	localparam int CONTROL_ENABLE_BIT = 0;
	localparam int STATE_IN_PACKET_BIT = 0;
	localparam int STATE_READY_BIT = 1;
	localparam int EVENT_UNDERFLOW_BIT = 0;
	localparam int EVENT_BAD_BIT = 1;
	localparam int EVENT_DONE_BIT = 2;

	// Reset values
	localparam logic CONTROL_ENABLE_RESET = 1'b1;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// Error control code placed in every byte lane of the replaced word
	localparam logic [63:0] ERROR_WORD = 64'hFEFE_FEFE_FEFE_FEFE;

	typedef struct packed {
		logic in_packet;
		logic enable;
		logic [2:0] event_bits;
		logic [2:0] mask;
		logic [15:0] packets;
		logic [31:0] rdata;
		logic [127:0] data;
		logic [1:0] valid;
		logic [1:0] start;
		logic [1:0] finish;
		logic [1:0] no_fcs;
		logic [5:0] empty;
		logic underflow;
	} sts_state_s;
endpackage : sts_pkg

// ==== bench/sts_link_sink.sv ====
// Downstream link model that throttles the port with random stalls
module sts_link_sink (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic stall_en,
	output logic link_ready
);
	timeunit 1ns;
	timeprecision 1ns;

	// A quarter of cycles stall so that ready drops mid-packet
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			link_ready <= 1'b0;
		else
			link_ready <= !stall_en || ($urandom % 4 != 0);
endmodule : sts_link_sink

// ==== bench/sts_tx_port_tb.sv ====
// Self-checking bench for the segmented transmit stream port
module sts_tx_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tvalid = 1'b0;
	logic stall_en = 1'b0;
	logic rd_seen = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [13:0] sb = 14'h0000;
	logic [127:0] tdata = 128'h0;
	logic link_ready, tready, irq, underflow;
	logic [31:0] rdata;
	logic [127:0] link_data, dm;
	logic [1:0] lv, ls, le, lnf, rs, rf;
	logic [2:0] le0, le1;
	logic [141:0] q;
	logic [141:0] sq[$];
	logic [31:0] rq[$];
	int err_count = 0;
	int n_compared = 0;
	int ends = 0;

	sts_tx_port dut (.clock(clock), .reset_n(reset_n), .reg_address(addr), .reg_write_data(wdata), .reg_write(wr),
		.reg_read(rd), .reg_read_data(rdata), .irq(irq), .tready(tready), .tvalid(tvalid), .tdata(tdata),
		.segment0_enable(sb[0]), .segment1_enable(sb[1]), .segment0_packet_start(sb[2]),
		.segment1_packet_start(sb[3]), .segment0_packet_end(sb[4]), .segment1_packet_end(sb[5]),
		.segment0_packet_bad(sb[6]), .segment1_packet_bad(sb[7]), .segment0_empty_count(sb[10:8]),
		.segment1_empty_count(sb[13:11]), .link_ready(link_ready), .link_data(link_data), .link_valid(lv),
		.link_start(ls), .link_end(le), .link_no_fcs(lnf), .link_empty0(le0), .link_empty1(le1),
		.underflow(underflow));
	sts_link_sink sink (.clock(clock), .reset_n(reset_n), .stall_en(stall_en), .link_ready(link_ready));

	initial
		forever #20 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [141:0] seen, input logic [141:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("compared=%0d errors=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	function automatic logic [127:0] rnd128();
		return {$urandom, $urandom, $urandom, $urandom};
	endfunction : rnd128

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] x);
		addr <= a;
		rd <= 1'b1;
		rq.push_back(x);
		@(posedge clock);
		rd <= 1'b0;
		@(posedge clock);
	endtask : rd_reg

	// Holds the beat until ready is seen, then notes what the link side must show
	task automatic beat(input logic [1:0] e, s, f, b, input logic [2:0] x0, x1, input logic [127:0] d);
		logic [127:0] dx;
		dx = d;
		tvalid <= 1'b1;
		sb <= {x1, x0, b, f, s, e};
		tdata <= d;
		do @(posedge clock); while (tready !== 1'b1);
		for (int i = 0; i < 2; i++)
			if (e[i] & f[i] & b[i])
				dx[64 * i +: 64] = sts_pkg::ERROR_WORD;
		if (e != 2'h0)
			sq.push_back({e, s & e, f & e, b & f & e, (e[0] & f[0]) ? x0 : 3'h0, (e[1] & f[1]) ? x1 : 3'h0, dx});
		ends += $countones(f & e);
	endtask : beat

	// Junk on every sideband while valid is low must be ignored
	task automatic idle();
		tvalid <= 1'b0;
		sb <= 14'h3fff;
		@(posedge clock);
	endtask : idle

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clock)
	begin
		if (rd_seen)
			check({110'h0, rdata}, {110'h0, rq.pop_front()});
		rd_seen = rd;
		if (lv != 2'h0)
		begin
			q = sq.pop_front();
			dm = {{64{lv[1]}}, {64{lv[0]}}};
			check({lv, ls, le, lnf, le0, le1, link_data & dm}, {q[141:128], q[127:0] & dm});
		end
	end

	initial
	begin
		#400000;
		err_count++;
		give_verdict();
	end

	initial
	begin
		void'($urandom(46));
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rd_reg(sts_pkg::CONTROL_ADDR, 32'h0000_0001);
		rd_reg(sts_pkg::MASK_ADDR, 32'h0000_0000);
		rd_reg(8'h20, 32'h0000_0000);
		beat(2'h3, 2'h1, 2'h0, 2'h0, 3'h0, 3'h0, rnd128());
		beat(2'h1, 2'h0, 2'h1, 2'h1, 3'h2, 3'h0, rnd128());
		beat(2'h3, 2'h2, 2'h1, 2'h0, 3'h5, 3'h0, rnd128());
		beat(2'h2, 2'h0, 2'h2, 2'h2, 3'h0, 3'h7, rnd128());
		idle();
		stall_en <= 1'b1;
		repeat (200)
		begin
			rs = 2'h1 << $urandom_range(0, 2);
			rf = 2'h1 << $urandom_range(0, 2);
			beat(2'($urandom), rs, rf, rf & 2'($urandom), rf[0] ? 3'($urandom) : 3'h0, rf[1] ? 3'($urandom) : 3'h0,
				rnd128());
		end
		beat(2'h1, 2'h0, 2'h1, 2'h0, 3'h0, 3'h0, rnd128());
		idle();
		stall_en <= 1'b0;
		wr_reg(sts_pkg::EVENT_ADDR, 32'h0000_0007);
		// Mask in underflow before the starved cycle so the interrupt path is exercised
		wr_reg(sts_pkg::MASK_ADDR, 32'h0000_0001);
		rd_reg(sts_pkg::PACKETS_ADDR, 32'(ends[15:0]));
		beat(2'h1, 2'h1, 2'h0, 2'h0, 3'h0, 3'h0, rnd128());
		idle();
		beat(2'h1, 2'h0, 2'h1, 2'h0, 3'h0, 3'h0, rnd128());
		check({141'h0, underflow}, {141'h0, 1'b1});
		idle();
		rd_reg(sts_pkg::EVENT_ADDR, 32'h0000_0005);
		check({141'h0, irq}, {141'h0, 1'b1});
		wr_reg(sts_pkg::EVENT_ADDR, 32'h0000_0001);
		check({141'h0, irq}, {141'h0, 1'b0});
		rd_reg(sts_pkg::STATE_ADDR, 32'h0000_0002);
		give_verdict();
	end
endmodule : sts_tx_port_tb
